// ==== core/omc_regs.svh ====
// Purpose: Register offsets, field positions, reset values for the mode control block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: Byte addresses; bits not listed read as zero
`ifndef OMC_REGS_SVH
`define OMC_REGS_SVH

`define OMC_MODE_CTRL_OFF   8'h00
`define OMC_EXT_FEAT_OFF    8'h04
`define OMC_LONG_CTRL_OFF   8'h08
`define OMC_PAGE_BASE_OFF   8'h0c
`define OMC_CODE_SEG_OFF    8'h10
`define OMC_PREFIX_OFF      8'h14
`define OMC_TABLE_LOAD_OFF  8'h18
`define OMC_STATUS_OFF      8'h1c
`define OMC_FAULT_OFF       8'h20
`define OMC_UPPER_BASE_OFF  8'h40

`define OMC_PROT_EN_BIT     0
`define OMC_PG_BIT          31
`define OMC_PAE_BIT         5
`define OMC_LME_BIT         8
`define OMC_LMA_BIT         10
`define OMC_CS_L_BIT        16
`define OMC_CS_D_BIT        17
`define OMC_PFX_OP64_BIT    0
`define OMC_PFX_OP16_BIT    1
`define OMC_PFX_AD32_BIT    2
`define OMC_FLT_GP_BIT      0
`define OMC_FLT_HAZ_BIT     1

`define OMC_CTRL_RST        32'h0000_0000
`define OMC_WORD_RST        32'h0000_0000
`define OMC_CS_SEL_RST      16'hf000

`endif

// ==== core/omc_pkg.sv ====
// Purpose: Types shared by the mode control block
// Assumes: Nothing beyond SystemVerilog packages
// Notes: Encodings also appear in the status word
package omc_pkg;
   typedef enum logic [1:0] {
      OMC_REAL = 2'b00,
      OMC_PROT = 2'b01,
      OMC_COMPAT = 2'b10,
      OMC_LONG64 = 2'b11
   } omc_mode_t;

   typedef enum logic [1:0] {
      OMC_SZ16 = 2'b00,
      OMC_SZ32 = 2'b01,
      OMC_SZ64 = 2'b10
   } omc_size_t;
endpackage

// ==== core/omc_mode_dec.sv ====
// Purpose: Decode execution mode and effective operand and address sizes
// Assumes: Flags come straight from control state, prefixes from software
// Notes: Purely combinational
module omc_mode_dec
   import omc_pkg::*;
(
   // Control state
   input logic prot_en,
   input logic lma,
   input logic cs_l,
   input logic cs_d,
   // Prefixes
   input logic pfx_op64,
   input logic pfx_op16,
   input logic pfx_ad32,
   // Results
   output omc_mode_t mode,
   output omc_size_t op_size,
   output omc_size_t addr_size
);
   // Legacy prefix flips 16 and 32
   function automatic omc_size_t flip_size(input logic wide, input logic flip);
      flip_size = (wide ^ flip) ? OMC_SZ32 : OMC_SZ16;
   endfunction

   wire in_long64 = prot_en && lma && cs_l;

   assign mode = !prot_en ? OMC_REAL : (!lma ? OMC_PROT : (cs_l ? OMC_LONG64 : OMC_COMPAT)); // RQ3 RQ6
   // Reserved L=1,D=1 still decodes as 64-bit; it is flagged in status
   assign op_size = in_long64 ? (pfx_op64 ? OMC_SZ64 : (pfx_op16 ? OMC_SZ16 : OMC_SZ32)) // RQ1 RQ2
                  : flip_size(prot_en && cs_d, pfx_op16); // RQ4
   assign addr_size = in_long64 ? (pfx_ad32 ? OMC_SZ32 : OMC_SZ64) // RQ1 RQ2
                    : flip_size(prot_en && cs_d, pfx_ad32); // RQ4
endmodule // omc_mode_dec

// ==== core/omc_upper_file.sv ====
// Purpose: Storage for the upper registers that only 64-bit code can write
// Assumes: Writer gates writes to 64-bit mode
// Notes: Contents are dropped once long mode is left
module omc_upper_file #(
   parameter int COUNT = 8,
   parameter int AW = 3
) (
   // Clock and reset
   input logic hclk,
   input logic hresetn,
   // Access
   input logic we,
   input logic [AW-1:0] waddr,
   input logic [31:0] wdata,
   input logic [AW-1:0] raddr,
   input logic invalidate,
   output logic [31:0] rdata,
   output logic all_valid
);
   generate
      if (COUNT < 1 || COUNT > (1 << AW)) begin : g_bad_count
         $error("COUNT must lie in 1..2**AW");
      end
   endgenerate

   logic [31:0] mem_r [COUNT];
   logic [COUNT-1:0] valid_r;

   always_ff @(posedge hclk) begin
      if (we) begin
         mem_r[waddr] <= wdata;
      end
   end

   // Undefined contents are shown as zero so reads never leak stale data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         valid_r <= '0;
      end else if (invalidate) begin
         valid_r <= '0; // RQ14
      end else if (we) begin
         valid_r[waddr] <= 1'b1;
      end
   end

   assign rdata = valid_r[raddr] ? mem_r[raddr] : 32'h0000_0000;
   assign all_valid = &valid_r;
endmodule // omc_upper_file

// ==== core/omc_ctrl.sv ====
// Purpose: Operating-mode control: mode flags, checked writes, size decode
// Assumes: AHB-Lite single-word transfers; event_req is synchronous to hclk
// Notes: Reads take one wait state, writes none
// What this block does and what software must do
// [RQ1] L=1,D=0 in long mode: 64-bit, op32/addr64
// [RQ2] 64-bit prefixes give op64/op16, addr32
// [RQ3] Long mode with L=0 is compatibility mode
// [RQ4] Compatibility: D selects 32 or 16 defaults
// [RQ5] Software avoids reserved L=1,D=1 code segments
// [RQ6] Mode chosen per code segment long bit
// [RQ7] Compatibility keeps long-mode translation, interrupts, syscalls
// [RQ8] Legacy interrupt table until reload; hazard flagged
// [RQ9] Software blocks interrupts until table reload
// [RQ10] Clearing paging in long mode drops active flag
// [RQ11] Software follows ordered long-mode exit steps
// [RQ12] Software branches right after paging re-enable
// [RQ13] Upper registers kept across compatibility round trip
// [RQ14] Upper registers undefined after legacy round trip
// [RQ15] Setting protection enters protected mode, paging optional
// [RQ16] Protected mode starts at privilege zero
// [RQ17] Software puts far transfer right after write
// [RQ18] Far transfer redirects and serializes
// [RQ19] Segments keep real contents until far reload
// [RQ20] Software follows recommended protected-mode entry order
// [RQ21] Software runs switch from identity-mapped page
// [RQ22] Paging on with long enable sets active
// [RQ23] Inconsistent long-mode writes raise protection fault
// [RQ24] Reset leaves real mode, all flags clear
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`include "omc_regs.svh"

module omc_ctrl
   import omc_pkg::*;
#(
   parameter int UPPER_COUNT = 8
) (
   // Clock and reset
   input logic hclk,
   input logic hresetn,
   // AHB-Lite slave
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic [2:0] hsize,
   input logic [31:0] hwdata,
   input logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Core side
   input logic event_req,
   output omc_mode_t exec_mode,
   output omc_size_t op_size,
   output omc_size_t addr_size,
   output logic long_semantics,
   output logic serialize,
   output logic gp_fault
);
   generate
      if (UPPER_COUNT < 1 || UPPER_COUNT > 8) begin : g_bad_count
         $error("UPPER_COUNT must lie in 1..8");
      end
   endgenerate

   // Bus pipeline
   logic dp_wr_r, dp_rd_r, rd_done_r;
   logic [7:0] dp_addr_r;
   logic [31:0] hrdata_r;
   // Mode state
   logic prot_en_r, pg_r, pae_r, lme_r, lma_r;
   logic [31:0] page_base_r;
   logic [15:0] cs_sel_r;
   logic cs_l_r, cs_d_r;
   logic [2:0] pfx_r;
   logic [31:0] table_base_r;
   logic legacy_table_r, seg_pending_r;
   logic [1:0] priv_lvl_r;
   logic flt_gp_r, flt_haz_r;
   logic serialize_r, gp_fault_r;

   // Address phase
   wire addr_take = hsel && hready && htrans[1] && (hsize == 3'b010);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r <= 1'b0;
         dp_rd_r <= 1'b0;
         dp_addr_r <= 8'h00;
      end else if (hready) begin
         dp_wr_r <= addr_take && hwrite;
         dp_rd_r <= addr_take && !hwrite;
         dp_addr_r <= haddr[7:0];
      end
   end

   // The read wait lets the read data be registered in hrdata_r before it is driven
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_done_r <= 1'b0;
      end else begin
         rd_done_r <= dp_rd_r && !rd_done_r;
      end
   end

   assign hreadyout = !(dp_rd_r && !rd_done_r);
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   // Register decode
   wire is_upper = (dp_addr_r[7:5] == 3'b010) && (32'(dp_addr_r[4:2]) < UPPER_COUNT);
   wire wr_mode = dp_wr_r && (dp_addr_r == `OMC_MODE_CTRL_OFF);
   wire wr_ext = dp_wr_r && (dp_addr_r == `OMC_EXT_FEAT_OFF);
   wire wr_long = dp_wr_r && (dp_addr_r == `OMC_LONG_CTRL_OFF);
   wire wr_base = dp_wr_r && (dp_addr_r == `OMC_PAGE_BASE_OFF);
   wire wr_cs = dp_wr_r && (dp_addr_r == `OMC_CODE_SEG_OFF);
   wire wr_pfx = dp_wr_r && (dp_addr_r == `OMC_PREFIX_OFF);
   wire wr_tbl = dp_wr_r && (dp_addr_r == `OMC_TABLE_LOAD_OFF);
   wire wr_flt = dp_wr_r && (dp_addr_r == `OMC_FAULT_OFF);

   wire new_prot_en = hwdata[`OMC_PROT_EN_BIT];
   wire new_pg = hwdata[`OMC_PG_BIT];
   wire new_pae = hwdata[`OMC_PAE_BIT];
   wire new_lme = hwdata[`OMC_LME_BIT];

   // Consistency checks on the long-mode enable bits
   wire pg_rise = new_pg && !pg_r;
   wire bad_mode = new_pg && (!new_prot_en || (pg_rise && lme_r && (!pae_r || cs_l_r))); // RQ23
   wire bad_long = (new_lme != lme_r) && pg_r; // RQ23
   wire bad_ext = !new_pae && lma_r; // RQ23
   wire fault_now = (wr_mode && bad_mode) || (wr_long && bad_long) || (wr_ext && bad_ext);
   wire mode_ok = wr_mode && !bad_mode;
   wire prot_en_rise = mode_ok && new_prot_en && !prot_en_r;
   wire lma_set = mode_ok && pg_rise && lme_r;
   wire lma_clr = mode_ok && !new_pg && pg_r && lma_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prot_en_r <= 1'b0; // RQ24
         pg_r <= 1'b0;
      end else if (mode_ok) begin
         prot_en_r <= new_prot_en; // RQ15
         pg_r <= new_pg; // RQ15
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lma_r <= 1'b0; // RQ24
      end else if (lma_set) begin
         lma_r <= 1'b1; // RQ22
      end else if (lma_clr) begin
         lma_r <= 1'b0; // RQ10
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lme_r <= 1'b0; // RQ24
         pae_r <= 1'b0;
         page_base_r <= `OMC_WORD_RST;
         pfx_r <= 3'h0;
         table_base_r <= `OMC_WORD_RST;
      end else begin
         if (wr_long && !bad_long) begin
            lme_r <= new_lme;
         end
         if (wr_ext && !bad_ext) begin
            pae_r <= new_pae;
         end
         if (wr_base) begin
            page_base_r <= hwdata;
         end
         if (wr_pfx) begin
            pfx_r <= hwdata[2:0];
         end
         if (wr_tbl) begin
            table_base_r <= hwdata;
         end
      end
   end

   // Code segment only changes through a far transfer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cs_sel_r <= `OMC_CS_SEL_RST;
         cs_l_r <= 1'b0;
         cs_d_r <= 1'b0;
         priv_lvl_r <= 2'h0;
         seg_pending_r <= 1'b0;
      end else if (wr_cs) begin
         cs_sel_r <= hwdata[15:0]; // RQ19
         cs_l_r <= hwdata[`OMC_CS_L_BIT]; // RQ6
         cs_d_r <= hwdata[`OMC_CS_D_BIT];
         priv_lvl_r <= prot_en_r ? hwdata[1:0] : 2'h0;
         seg_pending_r <= 1'b0; // RQ19
      end else if (prot_en_rise) begin
         priv_lvl_r <= 2'h0; // RQ16
         seg_pending_r <= 1'b1; // RQ19
      end
   end

   // Table stays legacy from long activation until reloaded or long mode is left
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         legacy_table_r <= 1'b0;
      end else if (lma_set) begin
         legacy_table_r <= 1'b1; // RQ8
      end else if (wr_tbl || lma_clr) begin
         legacy_table_r <= 1'b0;
      end
   end

   // Sticky faults: a new event beats a same-cycle clear
   wire haz_event = event_req && lma_r && legacy_table_r; // RQ8
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flt_gp_r <= 1'b0;
         flt_haz_r <= 1'b0;
      end else begin
         flt_gp_r <= fault_now || (flt_gp_r && !(wr_flt && hwdata[`OMC_FLT_GP_BIT]));
         flt_haz_r <= haz_event || (flt_haz_r && !(wr_flt && hwdata[`OMC_FLT_HAZ_BIT]));
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serialize_r <= 1'b0;
         gp_fault_r <= 1'b0;
      end else begin
         serialize_r <= wr_cs; // RQ18
         gp_fault_r <= fault_now; // RQ23
      end
   end

   assign serialize = serialize_r;
   assign gp_fault = gp_fault_r;
   assign long_semantics = lma_r; // RQ7

   omc_mode_dec u_dec (
      .prot_en(prot_en_r),
      .lma(lma_r),
      .cs_l(cs_l_r),
      .cs_d(cs_d_r),
      .pfx_op64(pfx_r[`OMC_PFX_OP64_BIT]),
      .pfx_op16(pfx_r[`OMC_PFX_OP16_BIT]),
      .pfx_ad32(pfx_r[`OMC_PFX_AD32_BIT]),
      .mode(exec_mode),
      .op_size(op_size),
      .addr_size(addr_size)
   );

   // Upper registers writable only from 64-bit code, kept through compatibility
   logic [31:0] upper_rdata;
   logic upper_valid;
   wire upper_we = dp_wr_r && is_upper && (exec_mode == OMC_LONG64);

   omc_upper_file #(
      .COUNT(UPPER_COUNT),
      .AW(3)
   ) u_upper (
      .hclk(hclk),
      .hresetn(hresetn),
      .we(upper_we),
      .waddr(dp_addr_r[4:2]),
      .wdata(hwdata),
      .raddr(dp_addr_r[4:2]),
      .invalidate(lma_clr), // RQ13 RQ14
      .rdata(upper_rdata),
      .all_valid(upper_valid)
   );

   // Read mux
   wire cs_reserved = cs_l_r && cs_d_r;
   wire [31:0] status_w = {16'h0000, 1'b0, cs_reserved, upper_valid, seg_pending_r,
      legacy_table_r, 1'b0, priv_lvl_r, addr_size, op_size, 2'b00, exec_mode};
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (dp_addr_r)
         `OMC_MODE_CTRL_OFF: rd_mux = {pg_r, 30'h0, prot_en_r};
         `OMC_EXT_FEAT_OFF: rd_mux = 32'(pae_r) << `OMC_PAE_BIT;
         `OMC_LONG_CTRL_OFF: rd_mux = (32'(lme_r) << `OMC_LME_BIT) | (32'(lma_r) << `OMC_LMA_BIT);
         `OMC_PAGE_BASE_OFF: rd_mux = page_base_r;
         `OMC_CODE_SEG_OFF: rd_mux = {14'h0, cs_d_r, cs_l_r, cs_sel_r};
         `OMC_PREFIX_OFF: rd_mux = {29'h0, pfx_r};
         `OMC_TABLE_LOAD_OFF: rd_mux = table_base_r;
         `OMC_STATUS_OFF: rd_mux = status_w;
         `OMC_FAULT_OFF: rd_mux = {30'h0, flt_haz_r, flt_gp_r};
         default: rd_mux = is_upper ? upper_rdata : 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
      end else if (dp_rd_r && !rd_done_r) begin
         hrdata_r <= rd_mux;
      end
   end

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_long_decode: assert property ( // RQ1
      lma_r && prot_en_r && cs_l_r && !cs_d_r && pfx_r == 3'h0
      |-> exec_mode == OMC_LONG64 && op_size == OMC_SZ32 && addr_size == OMC_SZ64)
      else $error("64-bit default sizes wrong");
   // The op16 prefix is judged only with op64 clear, so single-prefix stimulus reaches it
   chk_prefix_size: assert property ( // RQ2
      exec_mode == OMC_LONG64 && pfx_r != 3'h0
      |-> (!pfx_r[`OMC_PFX_OP64_BIT] || op_size == OMC_SZ64)
      && (pfx_r[`OMC_PFX_OP64_BIT] || !pfx_r[`OMC_PFX_OP16_BIT] || op_size == OMC_SZ16)
      && addr_size == (pfx_r[`OMC_PFX_AD32_BIT] ? OMC_SZ32 : OMC_SZ64))
      else $error("64-bit prefix override wrong");
   chk_compat_mode: assert property ( // RQ3
      prot_en_r && lma_r && !cs_l_r |-> exec_mode == OMC_COMPAT)
      else $error("compatibility mode not selected");
   chk_compat_size: assert property ( // RQ4
      exec_mode == OMC_COMPAT && pfx_r == 3'h0
      |-> op_size == (cs_d_r ? OMC_SZ32 : OMC_SZ16) && addr_size == op_size)
      else $error("compatibility default sizes wrong");
   chk_pg_clear: assert property ( // RQ10
      wr_mode && !bad_mode && lma_r && !new_pg |=> !lma_r && !pg_r)
      else $error("long mode not left on paging clear");
   chk_lma_set: assert property ( // RQ22
      wr_mode && !bad_mode && !pg_r && new_pg && lme_r |=> lma_r && legacy_table_r)
      else $error("long mode not activated");
   chk_gp_fault: assert property ( // RQ23
      wr_long && pg_r && (new_lme != lme_r)
      |=> gp_fault && $stable(lme_r) ##1 (!gp_fault || $past(dp_wr_r)))
      else $error("inconsistent write not faulted");
   chk_prot_entry: assert property ( // RQ16
      $rose(prot_en_r) |-> priv_lvl_r == 2'h0 && seg_pending_r)
      else $error("protected entry not at privilege zero");
   chk_table_hazard: assert property ( // RQ8
      event_req && lma_r && legacy_table_r |=> flt_haz_r)
      else $error("legacy table hazard missed");
   chk_serialize_pulse: assert property ( // RQ18
      wr_cs |=> serialize && !seg_pending_r ##1 (!serialize || $past(dp_wr_r)))
      else $error("far transfer did not serialize");
endmodule // omc_ctrl

// ==== tb/cpu_operating_mode_control_test.sv ====
// Purpose: Self-checking bench for the operating-mode control block
// Assumes: One AHB-Lite master, single word transfers, hready tied to hreadyout
// Notes: Reads queue their expectation; a monitor compares when the data phase ends
`include "omc_regs.svh"

module cpu_operating_mode_control_test
   import omc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic event_req = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout;
   logic hresp;
   logic serialize;
   logic gp_fault;
   logic long_semantics;
   logic [31:0] hrdata;
   omc_mode_t exec_mode;
   omc_size_t op_size;
   omc_size_t addr_size;
   logic [63:0] note_q[$];
   logic [63:0] note;
   logic rd_pend = 1'b0;
   logic [31:0] seed = 32'h0000_0061;
   logic [31:0] saved [8];
   int err_count = 0;
   int total_checks = 0;
   int gp_cnt = 0;
   int ser_cnt = 0;
   int rd_wait = 0;

   omc_ctrl #(.UPPER_COUNT(8)) omc_ctrl_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .event_req(event_req),
      .exec_mode(exec_mode), .op_size(op_size), .addr_size(addr_size),
      .long_semantics(long_semantics), .serialize(serialize), .gp_fault(gp_fault)
   );

   initial begin
      forever #5 hclk = ~hclk;
   end

   function automatic logic [31:0] next_rand(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // hreadyout only settles after the edge, so it is judged at the falling edge
   task automatic wait_rdy;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      note_q.push_back({m, e});
      xfer(1'b0, a, 32'h0);
   endtask

   // Write, confirm refusal or acceptance through the sticky fault, then the status
   task automatic step(input logic [7:0] a, input logic [31:0] d, input logic g,
                       input logic [31:0] m, input logic [31:0] e);
      wr(a, d);
      rd(`OMC_FAULT_OFF, 32'h1, {31'h0, g});
      wr(`OMC_FAULT_OFF, 32'h1);
      if (m != 32'h0) rd(`OMC_STATUS_OFF, m, e);
   endtask

   task automatic pulse_event;
      event_req <= 1'b1;
      @(posedge hclk);
      event_req <= 1'b0;
   endtask

   always @(posedge hclk) begin
      if (gp_fault === 1'b1) gp_cnt++;
      if (serialize === 1'b1) ser_cnt++;
      if (rd_pend && hreadyout !== 1'b1) rd_wait++;
      if (rd_pend && hreadyout === 1'b1) begin
         rd_pend <= 1'b0;
         note = (note_q.size() > 0) ? note_q.pop_front() : 64'hffff_ffff_dead_beef;
         check(hrdata & note[63:32], note[31:0]);
         check(hresp, 32'h0);
         // Reads carry exactly one wait state
         check(rd_wait, 32'd1);
         rd_wait = 0;
      end
      if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1) rd_pend <= 1'b1;
   end

   initial begin
      #200000;
      err_count++;
      summarize();
   end

   initial begin
      logic [1:0] ld_tab [3];
      logic [2:0] pf_tab [4];
      logic [1:0] ld;
      logic [2:0] pf;
      logic [1:0] md;
      logic [1:0] op;
      logic [1:0] ad;
      ld_tab = '{2'h0, 2'h1, 2'h2};
      pf_tab = '{3'h0, 3'h1, 3'h2, 3'h4};
      repeat (6) @(posedge hclk);
      check(exec_mode, OMC_REAL);
      check(long_semantics, 32'h0);
      hresetn <= 1'b1;
      rd(`OMC_MODE_CTRL_OFF, 32'hffff_ffff, 32'h0);
      rd(`OMC_LONG_CTRL_OFF, 32'hffff_ffff, 32'h0);
      rd(`OMC_CODE_SEG_OFF, 32'hffff_ffff, 32'h0000_f000);
      rd(`OMC_STATUS_OFF, 32'h0000_7ff3, 32'h0);
      rd(8'h30, 32'hffff_ffff, 32'h0);
      $display("reset test done");

      step(`OMC_MODE_CTRL_OFF, 32'h8000_0000, 1'b1, 32'h3, 32'h0);
      step(`OMC_MODE_CTRL_OFF, 32'h8000_0001, 1'b0, 32'h1303, 32'h1001);
      step(`OMC_LONG_CTRL_OFF, 32'h100, 1'b1, 32'h0, 32'h0);
      step(`OMC_MODE_CTRL_OFF, 32'h1, 1'b0, 32'h3, 32'h1);
      step(`OMC_LONG_CTRL_OFF, 32'h100, 1'b0, 32'h0, 32'h0);
      step(`OMC_MODE_CTRL_OFF, 32'h8000_0001, 1'b1, 32'h0, 32'h0);
      step(`OMC_EXT_FEAT_OFF, 32'h20, 1'b0, 32'h0, 32'h0);
      step(`OMC_CODE_SEG_OFF, 32'h1_0008, 1'b0, 32'h1000, 32'h0);
      step(`OMC_MODE_CTRL_OFF, 32'h8000_0001, 1'b1, 32'h0, 32'h0);
      step(`OMC_CODE_SEG_OFF, 32'h2_0008, 1'b0, 32'h13f3, 32'h51);
      step(`OMC_MODE_CTRL_OFF, 32'h8000_0001, 1'b0, 32'h0ff3, 32'h852);
      step(`OMC_EXT_FEAT_OFF, 32'h0, 1'b1, 32'h0, 32'h0);
      step(`OMC_LONG_CTRL_OFF, 32'h0, 1'b1, 32'h0, 32'h0);
      rd(`OMC_LONG_CTRL_OFF, 32'hffff_ffff, 32'h500);
      check(long_semantics, 32'h1);
      check(gp_cnt, 32'd6);
      check(ser_cnt, 32'd2);
      $display("mode switch test done");

      for (int c = 0; c < 3; c++) begin
         for (int p = 0; p < 4; p++) begin
            ld = ld_tab[c];
            pf = pf_tab[p];
            if (ld[1]) begin
               md = 2'h3;
               op = pf[0] ? 2'h2 : (pf[1] ? 2'h0 : 2'h1);
               ad = pf[2] ? 2'h1 : 2'h2;
            end else begin
               md = 2'h2;
               op = {1'b0, ld[0] ^ pf[1]};
               ad = {1'b0, ld[0] ^ pf[2]};
            end
            wr(`OMC_CODE_SEG_OFF, {14'h0, ld[0], ld[1], 16'h0008});
            wr(`OMC_PREFIX_OFF, {29'h0, pf});
            rd(`OMC_STATUS_OFF, 32'hf3, {24'h0, ad, op, 2'h0, md});
            check(exec_mode, md);
            check(addr_size, ad);
            check(op_size, op);
            check(long_semantics, 32'h1);
         end
      end
      wr(`OMC_PREFIX_OFF, 32'h0);
      $display("size decode test done");

      wr(`OMC_CODE_SEG_OFF, 32'h1_0008);
      for (int i = 0; i < 8; i++) begin
         seed = next_rand(seed);
         saved[i] = seed;
         wr(`OMC_UPPER_BASE_OFF + 8'(4 * i), seed);
      end
      wr(`OMC_CODE_SEG_OFF, 32'h0_0008);
      wr(`OMC_UPPER_BASE_OFF, ~saved[0]);
      wr(`OMC_CODE_SEG_OFF, 32'h1_0008);
      for (int i = 0; i < 8; i++) begin
         rd(`OMC_UPPER_BASE_OFF + 8'(4 * i), 32'hffff_ffff, saved[i]);
      end
      rd(`OMC_STATUS_OFF, 32'h2000, 32'h2000);
      pulse_event();
      rd(`OMC_FAULT_OFF, 32'h2, 32'h2);
      wr(`OMC_FAULT_OFF, 32'h3);
      seed = next_rand(seed);
      wr(`OMC_TABLE_LOAD_OFF, seed);
      rd(`OMC_STATUS_OFF, 32'h800, 32'h0);
      pulse_event();
      rd(`OMC_FAULT_OFF, 32'h3, 32'h0);
      $display("upper register test done");

      // Leave long mode the ordered way, then come back up as paged protected
      wr(`OMC_CODE_SEG_OFF, 32'h2_0008);
      step(`OMC_MODE_CTRL_OFF, 32'h1, 1'b0, 32'h3, 32'h1);
      check(long_semantics, 32'h0);
      rd(`OMC_LONG_CTRL_OFF, 32'hffff_ffff, 32'h100);
      seed = next_rand(seed);
      wr(`OMC_PAGE_BASE_OFF, seed);
      rd(`OMC_PAGE_BASE_OFF, 32'hffff_ffff, seed);
      step(`OMC_LONG_CTRL_OFF, 32'h0, 1'b0, 32'h0, 32'h0);
      step(`OMC_MODE_CTRL_OFF, 32'h8000_0001, 1'b0, 32'h3, 32'h1);
      wr(`OMC_CODE_SEG_OFF, 32'h2_0008);
      rd(`OMC_LONG_CTRL_OFF, 32'hffff_ffff, 32'h0);
      rd(`OMC_UPPER_BASE_OFF, 32'hffff_ffff, 32'h0);
      rd(`OMC_STATUS_OFF, 32'h2000, 32'h0);
      $display("long mode exit test done");

      @(posedge hclk);
      check(note_q.size(), 32'h0);
      summarize();
   end
endmodule // cpu_operating_mode_control_test
